// >>> rtl/fcm_cfg.svh
`ifndef FCM_CFG_SVH
`define FCM_CFG_SVH

// Clock and bus-cycle timing
`define FCM_CLK_NS      50
`define FCM_CYC(ns)     (((ns) + `FCM_CLK_NS - 1) / `FCM_CLK_NS)
`define FCM_T_WP_NS     35
`define FCM_T_ACC_NS    70
`define FCM_T_RP_NS     500
`define FCM_CNT_W       4

// Flash pin widths
`define FCM_ADDR_W      21
`define FCM_DATA_W      16

// Command words, kept configurable since parts differ
`define FCM_UNLK1_ADDR  21'h00_0555
`define FCM_UNLK1_DATA  16'h00AA
`define FCM_UNLK2_ADDR  21'h00_02AA
`define FCM_UNLK2_DATA  16'h0055
`define FCM_CMD_PROG    16'h00A0
`define FCM_CMD_AUTOSEL 16'h0090
`define FCM_CMD_BYPASS  16'h0020
`define FCM_CMD_BYP_X1  16'h0090
`define FCM_CMD_BYP_X2  16'h0000
`define FCM_CMD_RESET   16'h00F0

// Status bits in read data
`define FCM_POLL_BIT    7
`define FCM_TMO_BIT     5

// Register byte offsets
`define FCM_OFF_CTRL    8'h00
`define FCM_OFF_ADDR    8'h04
`define FCM_OFF_WDATA   8'h08
`define FCM_OFF_STATUS  8'h0C
`define FCM_OFF_RDATA   8'h10

// Control register fields
`define FCM_CTRL_OP_LSB 0
`define FCM_CTRL_OP_MSB 2
`define FCM_CTRL_GO     4
`define FCM_CTRL_BYTE   8

// Status register fields
`define FCM_ST_BUSY     0
`define FCM_ST_DONE     1
`define FCM_ST_ERR      2
`define FCM_ST_AUTOSEL  3
`define FCM_ST_BYPASS   4
`define FCM_ST_RDY      5
`define FCM_ST_BYTE     6

`define FCM_RESP_OKAY   2'h0
`define FCM_RESP_SLVERR 2'h2

`endif

// >>> rtl/fcm_pkg.sv
package fcm_pkg;

  typedef enum logic [2:0] {
    FCM_OP_READ     = 3'h0,
    FCM_OP_PROGRAM  = 3'h1,
    FCM_OP_RESET    = 3'h2,
    FCM_OP_AUTOSEL  = 3'h3,
    FCM_OP_BYP_IN   = 3'h4,
    FCM_OP_BYP_PROG = 3'h5,
    FCM_OP_BYP_OUT  = 3'h6,
    FCM_OP_HWRST    = 3'h7
  } fcm_op_t;

  typedef enum logic [9:0] {
    FCM_S_IDLE  = 10'h001,
    FCM_S_UNLK1 = 10'h002,
    FCM_S_UNLK2 = 10'h004,
    FCM_S_CMD   = 10'h008,
    FCM_S_CMD2  = 10'h010,
    FCM_S_PGM   = 10'h020,
    FCM_S_POLL  = 10'h040,
    FCM_S_RST   = 10'h080,
    FCM_S_RD    = 10'h100,
    FCM_S_HWRST = 10'h200
  } fcm_state_t;

  typedef enum logic [3:0] {
    FCM_CY_IDLE   = 4'h1,
    FCM_CY_SETUP  = 4'h2,
    FCM_CY_STROBE = 4'h4,
    FCM_CY_HOLD   = 4'h8
  } fcm_cyc_t;

endpackage

// >>> rtl/fcm_bus_cycle.sv
`timescale 1ns/10ps
`include "fcm_cfg.svh"

module fcm_bus_cycle import fcm_pkg::*; #(
  parameter int ADDR_W  = `FCM_ADDR_W,
  parameter int DATA_W  = `FCM_DATA_W,
  parameter int WP_CYC  = `FCM_CYC(`FCM_T_WP_NS),
  parameter int ACC_CYC = `FCM_CYC(`FCM_T_ACC_NS)
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // Cycle request
  input  wire logic              start,
  input  wire logic              is_read,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   done,
  output logic [DATA_W-1:0]      rdata,
  // Flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n
);

  localparam logic [`FCM_CNT_W-1:0] WP_LAST  = `FCM_CNT_W'(WP_CYC - 1);
  localparam logic [`FCM_CNT_W-1:0] ACC_LAST = `FCM_CNT_W'(ACC_CYC - 1);

  fcm_cyc_t               st_q;
  logic                   rd_q;
  logic [`FCM_CNT_W-1:0]  cnt_q;
  wire                    cnt_end = (cnt_q == '0);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q         <= FCM_CY_IDLE;
      rd_q         <= 1'b0;
      cnt_q        <= '0;
      done         <= 1'b0;
      rdata        <= '0;
      flash_addr   <= '0;
      flash_dq_out <= '0;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_q)
        FCM_CY_IDLE: begin
          if (start) begin
            // Address settles with chip select, before any write strobe
            flash_addr   <= addr;
            flash_dq_out <= wdata;
            rd_q         <= is_read;
            flash_ce_n   <= 1'b0;
            flash_oe_n   <= !is_read;
            st_q         <= FCM_CY_SETUP;
          end
        end
        FCM_CY_SETUP: begin
          flash_we_n  <= rd_q;
          flash_dq_oe <= !rd_q;
          cnt_q       <= rd_q ? ACC_LAST : WP_LAST;
          st_q        <= FCM_CY_STROBE;
        end
        FCM_CY_STROBE: begin
          // Every strobe is a whole clock or more, far above glitch width
          if (cnt_end) begin
            flash_we_n <= 1'b1;
            if (rd_q) begin
              rdata <= flash_dq_in;
            end
            st_q <= FCM_CY_HOLD;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        FCM_CY_HOLD: begin
          // Data held one cycle past the write-strobe rise
          flash_ce_n  <= 1'b1;
          flash_oe_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          done        <= 1'b1;
          st_q        <= FCM_CY_IDLE;
        end
        default: st_q <= FCM_CY_IDLE;
      endcase
    end
  end

endmodule

// >>> rtl/fcm_host.sv
`timescale 1ns/10ps
`include "fcm_cfg.svh"

module fcm_host import fcm_pkg::*; #(
  parameter int ADDR_W  = `FCM_ADDR_W,
  parameter int DATA_W  = `FCM_DATA_W,
  parameter int RST_CYC = `FCM_CYC(`FCM_T_RP_NS)
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // AXI4-Lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   width_select_n,
  output logic                   hw_reset_n,
  input  wire logic              ready_busy_n
);

  localparam logic [9:0] RST_LAST = 10'(RST_CYC - 1);

  // Register state
  fcm_state_t         st_q;
  fcm_op_t            op_q;
  logic [ADDR_W-1:0]  addr_q;
  logic [DATA_W-1:0]  wdat_q;
  logic [DATA_W-1:0]  rdat_q;
  logic               byte_q, done_q, err_q, autosel_q, bypass_q;
  logic               issued_q, second_q, cyc_start_q;
  logic [9:0]         rst_cnt_q;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               aw_have_q, w_have_q;
  logic               cyc_done;
  logic [DATA_W-1:0]  cyc_rdata;

  // Bus-side decode
  wire        wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  wire [31:0] wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire        wr_ctrl = wr_fire && (awaddr_q == `FCM_OFF_CTRL) && wstrb_q[0];
  wire        wr_addr = wr_fire && (awaddr_q == `FCM_OFF_ADDR);
  wire        wr_wdat = wr_fire && (awaddr_q == `FCM_OFF_WDATA);
  wire        wr_map  = (awaddr_q == `FCM_OFF_CTRL) ||
                        (awaddr_q == `FCM_OFF_ADDR) ||
                        (awaddr_q == `FCM_OFF_WDATA);
  wire [31:0] addr_new = (32'(addr_q) & ~wmask) | (wdata_q & wmask);
  wire [31:0] wdat_new = (32'(wdat_q) & ~wmask) | (wdata_q & wmask);
  wire        go       = wr_ctrl && wdata_q[`FCM_CTRL_GO] && st_q == FCM_S_IDLE;
  wire        byte_wr  = wr_fire && (awaddr_q == `FCM_OFF_CTRL) && wstrb_q[1];
  fcm_op_t    go_op;
  assign go_op = fcm_op_t'(wdata_q[`FCM_CTRL_OP_MSB:`FCM_CTRL_OP_LSB]);

  // Bypass mode admits only its own program and exit, and the hardware reset
  wire go_bad = bypass_q ? !(go_op == FCM_OP_BYP_PROG ||
                             go_op == FCM_OP_BYP_OUT ||
                             go_op == FCM_OP_HWRST)
                         : (go_op == FCM_OP_BYP_PROG ||
                            go_op == FCM_OP_BYP_OUT);

  wire [31:0] status = {25'h00_0000,
                        byte_q, ready_busy_n, bypass_q, autosel_q,
                        err_q, done_q, st_q != FCM_S_IDLE};

  // Bus cycle contents per state
  wire              is_rd_st = (st_q == FCM_S_POLL) || (st_q == FCM_S_RD);
  wire              bus_st   = (st_q != FCM_S_IDLE) && (st_q != FCM_S_HWRST);
  wire [DATA_W-1:0] cmd_code =
    (op_q == FCM_OP_AUTOSEL) ? `FCM_CMD_AUTOSEL :
    (op_q == FCM_OP_BYP_IN)  ? `FCM_CMD_BYPASS :
    (op_q == FCM_OP_BYP_OUT) ? `FCM_CMD_BYP_X1 :
    (op_q == FCM_OP_RESET)   ? `FCM_CMD_RESET : `FCM_CMD_PROG;
  wire [ADDR_W-1:0] cyc_addr =
    (st_q == FCM_S_UNLK2) ? `FCM_UNLK2_ADDR :
    (st_q == FCM_S_PGM || is_rd_st) ? addr_q : `FCM_UNLK1_ADDR;
  wire [DATA_W-1:0] cyc_wdata =
    (st_q == FCM_S_UNLK1) ? `FCM_UNLK1_DATA :
    (st_q == FCM_S_UNLK2) ? `FCM_UNLK2_DATA :
    (st_q == FCM_S_CMD)   ? cmd_code :
    (st_q == FCM_S_CMD2)  ? `FCM_CMD_BYP_X2 :
    (st_q == FCM_S_RST)   ? `FCM_CMD_RESET : wdat_q;
  wire poll_ok  = cyc_rdata[`FCM_POLL_BIT] == wdat_q[`FCM_POLL_BIT];
  wire poll_tmo = cyc_rdata[`FCM_TMO_BIT];

  fcm_bus_cycle #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_cycle (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .start        (cyc_start_q),
    .is_read      (is_rd_st),
    .addr         (cyc_addr),
    .wdata        (cyc_wdata),
    .done         (cyc_done),
    .rdata        (cyc_rdata),
    .flash_addr   (flash_addr),
    .flash_dq_in  (flash_dq_in),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n)
  );

  // AXI write channels: one write in flight
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FCM_RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `FCM_RESP_OKAY : `FCM_RESP_SLVERR;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI read channel, answered the cycle after the address
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `FCM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `FCM_RESP_OKAY;
      if (s_axi_araddr == `FCM_OFF_CTRL) begin
        s_axi_rdata <= {23'h00_0000, byte_q, 5'h00, op_q};
      end else if (s_axi_araddr == `FCM_OFF_ADDR) begin
        s_axi_rdata <= 32'(addr_q);
      end else if (s_axi_araddr == `FCM_OFF_WDATA) begin
        s_axi_rdata <= 32'(wdat_q);
      end else if (s_axi_araddr == `FCM_OFF_STATUS) begin
        s_axi_rdata <= status;
      end else if (s_axi_araddr == `FCM_OFF_RDATA) begin
        s_axi_rdata <= 32'(rdat_q);
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= `FCM_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Software-held registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q         <= '0;
      wdat_q         <= '0;
      byte_q         <= 1'b0;
      width_select_n <= 1'b1;
    end else begin
      if (wr_addr && st_q == FCM_S_IDLE) begin
        addr_q <= addr_new[ADDR_W-1:0];
      end
      if (wr_wdat && st_q == FCM_S_IDLE) begin
        wdat_q <= wdat_new[DATA_W-1:0];
      end
      if (byte_wr && st_q == FCM_S_IDLE) begin
        byte_q         <= wdata_q[`FCM_CTRL_BYTE];
        width_select_n <= !wdata_q[`FCM_CTRL_BYTE];
      end
    end
  end

  // Command sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q        <= FCM_S_IDLE;
      op_q        <= FCM_OP_READ;
      rdat_q      <= '0;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
      autosel_q   <= 1'b0;
      bypass_q    <= 1'b0;
      issued_q    <= 1'b0;
      second_q    <= 1'b0;
      cyc_start_q <= 1'b0;
      rst_cnt_q   <= '0;
      hw_reset_n  <= 1'b1;
    end else begin
      cyc_start_q <= bus_st && !issued_q && !cyc_start_q;
      if (cyc_start_q) begin
        issued_q <= 1'b1;
      end
      case (st_q)
        FCM_S_IDLE: begin
          if (go && go_bad) begin
            err_q  <= 1'b1;
            done_q <= 1'b0;
          end else if (go) begin
            op_q     <= go_op;
            done_q   <= 1'b0;
            err_q    <= 1'b0;
            second_q <= 1'b0;
            if (go_op == FCM_OP_READ) begin
              st_q <= FCM_S_RD;
            end else if (go_op == FCM_OP_HWRST) begin
              st_q       <= FCM_S_HWRST;
              rst_cnt_q  <= RST_LAST;
              hw_reset_n <= 1'b0;
            end else if (go_op == FCM_OP_RESET || bypass_q) begin
              st_q <= FCM_S_CMD;
            end else begin
              st_q <= FCM_S_UNLK1;
            end
          end
        end
        FCM_S_HWRST: begin
          if (rst_cnt_q == '0) begin
            hw_reset_n <= 1'b1;
            autosel_q  <= 1'b0;
            bypass_q   <= 1'b0;
            done_q     <= 1'b1;
            st_q       <= FCM_S_IDLE;
          end else begin
            rst_cnt_q <= rst_cnt_q - 1'b1;
          end
        end
        default: begin
          if (cyc_done) begin
            issued_q <= 1'b0;
            if (st_q == FCM_S_UNLK1) begin
              st_q <= FCM_S_UNLK2;
            end else if (st_q == FCM_S_UNLK2) begin
              st_q <= FCM_S_CMD;
            end else if (st_q == FCM_S_CMD) begin
              if (op_q == FCM_OP_PROGRAM || op_q == FCM_OP_BYP_PROG) begin
                st_q <= FCM_S_PGM;
              end else if (op_q == FCM_OP_BYP_OUT) begin
                st_q <= FCM_S_CMD2;
              end else begin
                autosel_q <= (op_q == FCM_OP_AUTOSEL);
                bypass_q  <= (op_q == FCM_OP_BYP_IN);
                done_q    <= 1'b1;
                st_q      <= FCM_S_IDLE;
              end
            end else if (st_q == FCM_S_CMD2) begin
              bypass_q <= 1'b0;
              done_q   <= 1'b1;
              st_q     <= FCM_S_IDLE;
            end else if (st_q == FCM_S_PGM) begin
              st_q <= FCM_S_POLL;
            end else if (st_q == FCM_S_POLL) begin
              rdat_q <= cyc_rdata;
              // Poll bit matching written data means the algorithm ended
              if (poll_ok) begin
                done_q <= 1'b1;
                st_q   <= FCM_S_IDLE;
              end else if (poll_tmo && second_q) begin
                err_q <= 1'b1;
                st_q  <= FCM_S_RST;
              end else begin
                second_q <= poll_tmo;
              end
            end else if (st_q == FCM_S_RST) begin
              autosel_q <= 1'b0;
              done_q    <= 1'b1;
              st_q      <= FCM_S_IDLE;
            end else begin
              rdat_q <= cyc_rdata;
              done_q <= 1'b1;
              st_q   <= FCM_S_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule

// >>> dv/fcm_host_asserts.sv
`timescale 1ns/10ps
module fcm_chk import fcm_pkg::*; #(
  parameter int RST_CYC = 10
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Flash pins
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        hw_reset_n,
  // Bus handshakes
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready
);
  logic [7:0] low_q;

  // Length of the reset pulse, counted while it is low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      low_q <= 8'h00;
    else
      low_q <= hw_reset_n ? 8'h00 : low_q + 8'h01;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_we_gated: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe outside a selected write");
  a_dq_no_clash: assert property (flash_dq_oe |-> flash_oe_n)
    else $error("data driven while output gate low");
  a_we_width: assert property ($fell(flash_we_n) |=> flash_we_n)
    else $error("write strobe pulse length wrong");
  a_addr_steady: assert property (!flash_ce_n && $past(!flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved during a cycle");
  a_data_steady: assert property (!flash_we_n |-> flash_dq_oe && $stable(flash_dq_out))
    else $error("data not held under write strobe");
  a_ce_gap: assert property ($rose(flash_ce_n) |-> flash_ce_n [*2])
    else $error("idle gap between cycles too short");
  a_hwrst_len: assert property ($rose(hw_reset_n) |-> low_q == 8'(RST_CYC))
    else $error("hardware reset pulse length wrong");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  c_write: cover property ($fell(flash_we_n));
  c_hwrst: cover property ($rose(hw_reset_n));
  c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule

bind fcm_host fcm_chk #(.RST_CYC(RST_CYC)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .flash_addr(flash_addr),
  .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .hw_reset_n(hw_reset_n),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready)
);

// >>> dv/fcm_flash_model.sv
`timescale 1ns/10ps
`include "fcm_cfg.svh"
module fcm_flash import fcm_pkg::*; #(
  parameter logic [15:0] MFR_CODE = 16'h00C1, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h2B7E, // Arbitrary value
  parameter int          BUSY_NS  = 3000
) (
  // Host-driven pins
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        hw_reset_n,
  // Device-driven pins
  output logic [15:0]      flash_dq_in,
  output logic             ready_busy_n
);
  logic [15:0] mem [256];
  logic [15:0] pd = 16'h0000, rdv = 16'h0000;
  logic [20:0] la = 21'h00_0000, pa = 21'h00_0000;
  logic [2:0]  st = 3'h0;
  logic        busy = 1'b0, fail = 1'b0, tog = 1'b0, drv = 1'b0;
  int          gen = 0;
  realtime     t_we = 0;
  event        pgm_ev;

  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  assign ready_busy_n = !busy;
  // Released bus shows the inverse, never a stale copy
  assign flash_dq_in = drv ? rdv : ~rdv;

  task automatic start_pgm(input logic [20:0] a, input logic [15:0] d);
    pa = a;
    pd = d;
    busy = 1'b1;
    fail = |(d & ~mem[a[7:0]]);
    if (!fail) -> pgm_ev;
  endtask

  task automatic cmd(input logic [20:0] a, input logic [15:0] d);
    if (busy && !(fail && d == `FCM_CMD_RESET)) return;
    if (d == `FCM_CMD_RESET && (st < 3'h5 || fail)) begin
      busy = 1'b0;
      fail = 1'b0;
      st = 3'h0;
      return;
    end
    case (st)
      3'h0: st = (a == `FCM_UNLK1_ADDR && d == `FCM_UNLK1_DATA) ? 3'h1 : 3'h0;
      3'h1: st = (a == `FCM_UNLK2_ADDR && d == `FCM_UNLK2_DATA) ? 3'h2 : 3'h0;
      3'h2: st = a != `FCM_UNLK1_ADDR ? 3'h0 : d == `FCM_CMD_PROG ? 3'h3 :
                 d == `FCM_CMD_AUTOSEL ? 3'h4 :
                 d == `FCM_CMD_BYPASS ? 3'h5 : 3'h0;
      3'h3: begin
        start_pgm(a, d);
        st = 3'h0;
      end
      3'h4: st = 3'h4;
      3'h5: st = d == `FCM_CMD_PROG ? 3'h6 :
                 d == `FCM_CMD_BYP_X1 ? 3'h7 : 3'h5;
      3'h6: begin
        start_pgm(a, d);
        st = 3'h5;
      end
      default: st = d == `FCM_CMD_BYP_X2 ? 3'h0 : 3'h5;
    endcase
  endtask

  always @(pgm_ev) begin
    int g;
    g = gen;
    #(BUSY_NS);
    if (g == gen) begin
      mem[pa[7:0]] = mem[pa[7:0]] & pd;
      busy = 1'b0;
    end
  end

  always @(negedge flash_we_n) begin
    t_we = $realtime;
    if (!flash_ce_n) la = flash_addr;
  end
  // First rising edge of strobe or select takes the data
  always @(posedge flash_we_n or posedge flash_ce_n) begin
    if ((flash_we_n ^ flash_ce_n) && flash_oe_n && hw_reset_n &&
        $realtime - t_we >= 5) cmd(la, flash_dq_out);
  end

  always @(negedge flash_oe_n) begin
    #1;
    tog = tog ^ busy;
    if (busy) rdv = {8'h00, ~pd[7], tog, fail, 5'h00};
    else if (st == 3'h4) rdv = flash_addr[7:0] == 8'h00 ? MFR_CODE :
      flash_addr[7:0] == 8'h01 ? DEV_CODE : 16'h0000;
    else rdv = mem[flash_addr[7:0]];
    drv = !flash_ce_n;
  end
  always @(posedge flash_oe_n) drv = 1'b0;

  always @(negedge hw_reset_n) begin
    st = 3'h0;
    busy = 1'b0;
    fail = 1'b0;
    gen = gen + 1;
  end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("Error %s expected %h seen %h", nm, exp, got); \
  end \
end

module tb_top;
  localparam logic [15:0] MFR = 16'h00C1; // Arbitrary value
  localparam logic [15:0] DEV = 16'h2B7E; // Arbitrary value
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic        awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        awr, wrd, bv, arr, rv, foe, fce, foen, fwe, wsn, hwn, rbn;
  logic [1:0]  bresp, rresp;
  logic [20:0] fa;
  logic [15:0] fdi, fdo;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;

  always #25 core_clk = ~core_clk;

  fcm_host #(.RST_CYC(2)) DUT (
    .core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .flash_addr(fa),
    .flash_dq_in(fdi), .flash_dq_out(fdo), .flash_dq_oe(foe),
    .flash_ce_n(fce), .flash_oe_n(foen), .flash_we_n(fwe),
    .width_select_n(wsn), .hw_reset_n(hwn), .ready_busy_n(rbn)
  );

  fcm_flash #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (
    .flash_addr(fa), .flash_dq_out(fdo), .flash_ce_n(fce),
    .flash_oe_n(foen), .flash_we_n(fwe), .hw_reset_n(hwn),
    .flash_dq_in(fdi), .ready_busy_n(rbn)
  );

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Tests take several hundred cycles; the ceiling of 20000 leaves a wide margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge core_clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    d = rdat;
    r = rresp;
  endtask

  task automatic op(input logic [2:0] o, output logic [31:0] s);
    logic [1:0] r;
    wr(8'h00, 32'h0000_0010 | 32'(o), r);
    do rd(8'h0C, s, r); while (s[2:1] == 2'h0);
  endtask

  task automatic pgm(input logic [2:0] o, input logic [20:0] a,
                     input logic [15:0] d, output logic [31:0] s);
    logic [1:0] r;
    wr(8'h04, 32'(a), r);
    wr(8'h08, 32'(d), r);
    op(o, s);
  endtask

  task automatic frd(input logic [20:0] a, output logic [15:0] d);
    logic [31:0] s;
    logic [1:0]  r;
    wr(8'h04, 32'(a), r);
    op(3'h0, s);
    rd(8'h10, s, r);
    d = s[15:0];
  endtask

  task automatic t_regs();
    logic [31:0] s;
    logic [1:0]  r;
    `CHK("idle pins", 6'h3B, {fce, foen, fwe, foe, wsn, hwn})
    rd(8'h0C, s, r);
    `CHK("idle status", 3'h4, {s[5], s[2], s[0]})
    rd(8'h40, s, r);
    `CHK("unmapped read", 34'h2_0000_0000, {r, s})
    wr(8'h44, 32'h0000_0001, r);
    `CHK("unmapped write", 2'h2, r)
    wr(8'h00, 32'h0000_0100, r);
    `CHK("byte pin", 1'b0, wsn)
    $display("test regs done");
  endtask

  task automatic t_prog();
    logic [31:0] s;
    logic [15:0] d;
    pgm(3'h1, 21'h00_0012, 16'h5A3C, s);
    `CHK("prog status", 2'h1, s[2:1])
    frd(21'h00_0012, d);
    `CHK("array data", 16'h5A3C, d)
    pgm(3'h1, 21'h00_0012, 16'hFFFF, s);
    `CHK("timeout err", 1'b1, s[2])
    frd(21'h00_0012, d);
    `CHK("zero kept", 16'h5A3C, d)
    $display("test prog done");
  endtask

  task automatic t_asel();
    logic [31:0] s;
    logic [15:0] d;
    op(3'h3, s);
    `CHK("autosel flag", 1'b1, s[3])
    frd(21'h00_0100, d);
    `CHK("maker code", MFR, d)
    frd(21'h00_0001, d);
    `CHK("device code", DEV, d)
    frd(21'h00_0002, d);
    `CHK("protect state", 16'h0000, d)
    op(3'h2, s);
    `CHK("autosel left", 1'b0, s[3])
    frd(21'h00_0012, d);
    `CHK("array again", 16'h5A3C, d)
    $display("test autoselect done");
  endtask

  task automatic t_byp();
    logic [31:0] s;
    logic [15:0] d;
    op(3'h4, s);
    `CHK("bypass flag", 1'b1, s[4])
    pgm(3'h5, 21'h00_0020, 16'h1234, s);
    `CHK("bypass prog", 2'h1, s[2:1])
    pgm(3'h5, 21'h00_0021, 16'h00FF, s);
    `CHK("bypass prog2", 2'h1, s[2:1])
    op(3'h1, s);
    `CHK("full prog refused", 1'b1, s[2])
    op(3'h6, s);
    `CHK("bypass left", 1'b0, s[4])
    frd(21'h00_0020, d);
    `CHK("bypass data", 16'h1234, d)
    frd(21'h00_0021, d);
    `CHK("bypass data2", 16'h00FF, d)
    $display("test bypass done");
  endtask

  task automatic t_hw();
    logic [31:0] s;
    logic [15:0] d;
    op(3'h7, s);
    `CHK("reset pin idle", 1'b1, hwn)
    frd(21'h00_0012, d);
    `CHK("read after reset", 16'h5A3C, d)
    $display("test hw reset done");
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_prog();
    t_asel();
    t_byp();
    t_hw();
    tally_and_finish();
  end
endmodule
